// ### verilog/cta_defines.svh
// Constants for the coherent transaction attribute checker.
// Assumes a 128-bit data bus, 32-bit addresses and a 64-byte cache line.
`ifndef CTA_DEFINES_SVH
`define CTA_DEFINES_SVH

// ****************************************************************
// Bus and line geometry
// ****************************************************************
`define CTA_ADDR_W 32
`define CTA_BUS_BYTES 16
`define CTA_BUS_LOG 3'h4
`define CTA_LINE_BYTES 16'h0040
`define CTA_LINE_LOG 6
`define CTA_LINE_MIN 16'h0010
`define CTA_LINE_MAX 16'h0800
`define CTA_MAX_BEATS 16'h0010
`define CTA_NVIOL 16
`define CTA_WQ_DEPTH 4
`define CTA_WQ_FULL 3'h4

// ****************************************************************
// Attribute encodings
// ****************************************************************
`define CTA_DOM_NS 2'h0
`define CTA_DOM_IS 2'h1
`define CTA_DOM_OS 2'h2
`define CTA_DOM_SYS 2'h3
`define CTA_BURST_FIXED 2'h0
`define CTA_BURST_INCR 2'h1
`define CTA_BURST_WRAP 2'h2
`define CTA_CACHE_MOD_BIT 1

// ****************************************************************
// Snoop encodings
// ****************************************************************
`define CTA_RS_ONCE 4'h0
`define CTA_RS_SHARED 4'h1
`define CTA_RS_CLEAN 4'h2
`define CTA_RS_NSD 4'h3
`define CTA_RS_UNIQUE 4'h7
`define CTA_RS_CLEAN_SH 4'h8
`define CTA_RS_CLEAN_INV 4'h9
`define CTA_RS_CLEAN_UNQ 4'hB
`define CTA_RS_MAKE_UNQ 4'hC
`define CTA_RS_MAKE_INV 4'hD
`define CTA_WS_UNIQUE 3'h0
`define CTA_WS_LINE_UNQ 3'h1
`define CTA_WS_CLEAN 3'h2
`define CTA_WS_BACK 3'h3
`define CTA_WS_EVICT 3'h4

// ****************************************************************
// Violation flag positions
// ****************************************************************
`define CTA_V_DOM_LINE 4'h0
`define CTA_V_DOM_MAINT 4'h1
`define CTA_V_BAR 4'h2
`define CTA_V_LOCK 4'h3
`define CTA_V_STRB 4'h4
`define CTA_V_LINE_LEN 4'h5
`define CTA_V_SIZE 4'h6
`define CTA_V_ALIGN 4'h7
`define CTA_V_BURST 4'h8
`define CTA_V_CACHE 4'h9
`define CTA_V_DOM_ONCE 4'hA
`define CTA_V_DOM_SYS 4'hB
`define CTA_V_DOM_TRUE 4'hC
`define CTA_V_WB_WRAP 4'hD
`define CTA_V_WB_INCR 4'hE
`define CTA_V_WQ_OVF 4'hF

`endif

// ### verilog/cta_pkg.sv
// Types shared by the coherent transaction attribute checker.
// Assumes cta_defines.svh is on the include path.
`include "cta_defines.svh"

package cta_pkg;
	typedef enum logic [3:0] {
		CTA_DOM_LINE = `CTA_V_DOM_LINE,
		CTA_DOM_MAINT = `CTA_V_DOM_MAINT,
		CTA_BAR = `CTA_V_BAR,
		CTA_LOCK = `CTA_V_LOCK,
		CTA_STRB = `CTA_V_STRB,
		CTA_LINE_LEN = `CTA_V_LINE_LEN,
		CTA_SIZE = `CTA_V_SIZE,
		CTA_ALIGN = `CTA_V_ALIGN,
		CTA_BURST = `CTA_V_BURST,
		CTA_CACHE = `CTA_V_CACHE,
		CTA_DOM_ONCE = `CTA_V_DOM_ONCE,
		CTA_DOM_SYS = `CTA_V_DOM_SYS,
		CTA_DOM_TRUE = `CTA_V_DOM_TRUE,
		CTA_WB_WRAP = `CTA_V_WB_WRAP,
		CTA_WB_INCR = `CTA_V_WB_INCR,
		CTA_WQ_OVF = `CTA_V_WQ_OVF
	} cta_viol_type;

	typedef enum logic [1:0] {
		CTA_W_IDLE = 2'h0,
		CTA_W_BURST = 2'h1
	} cta_wstate_type;
endpackage

// ### verilog/cta_addr_check.sv
// Combinational attribute check of one address channel request.
// Assumes the caller qualifies the result with the channel handshake.
`timescale 1ns/1ps
`default_nettype none
`include "cta_defines.svh"

module cta_addr_check
	import cta_pkg::*;
(
	input wire logic is_write,
	input wire logic [`CTA_ADDR_W-1:0] addr,
	input wire logic [7:0] len,
	input wire logic [2:0] size,
	input wire logic [1:0] burst,
	input wire logic lock,
	input wire logic [3:0] cache,
	input wire logic [1:0] domain,
	input wire logic [3:0] snoop,
	input wire logic bar,
	input wire logic filter_on,
	input wire logic [1:0] true_dom,
	output logic [`CTA_NVIOL-1:0] viol
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] cta_bytes(input logic [7:0] l, input logic [2:0] s);
		cta_bytes = 16'(({8'h00, l} + 16'h0001) << s);
	endfunction

	function automatic logic cta_pow2_len(input logic [7:0] l);
		cta_pow2_len = ((l & 8'(l + 8'h01)) == 8'h00) && (l < 8'h10);
	endfunction

	logic line_txn;
	logic maint;
	logic lock_ok;
	logic once_txn;
	logic wb_txn;
	logic report_txn;
	logic shareable;
	logic [15:0] bytes;
	logic [`CTA_ADDR_W-1:0] size_mask;
	logic [`CTA_ADDR_W-1:0] end_addr;

	// ****************************************************************
	// Decode and checks
	// ****************************************************************
	always_comb begin
		viol = '0;
		shareable = (domain == `CTA_DOM_IS) || (domain == `CTA_DOM_OS);
		bytes = cta_bytes(len, size);
		size_mask = `CTA_ADDR_W'((33'h1 << size) - 33'h1);
		end_addr = (addr & ~size_mask) + {16'h0000, bytes} - 32'h1;
		maint = 1'b0;
		lock_ok = 1'b0;
		wb_txn = 1'b0;
		report_txn = 1'b0;
		if (is_write) begin
			line_txn = (snoop[2:0] == `CTA_WS_LINE_UNQ) || (snoop[2:0] == `CTA_WS_EVICT);
			once_txn = (snoop[2:0] == `CTA_WS_UNIQUE) && shareable && !bar;
			wb_txn = (snoop[2:0] == `CTA_WS_BACK) || (snoop[2:0] == `CTA_WS_CLEAN);
			report_txn = wb_txn || (snoop[2:0] == `CTA_WS_EVICT);
		end else begin
			maint = (snoop == `CTA_RS_CLEAN_SH) || (snoop == `CTA_RS_CLEAN_INV) || (snoop == `CTA_RS_MAKE_INV);
			lock_ok = (snoop == `CTA_RS_CLEAN) || (snoop == `CTA_RS_SHARED) || (snoop == `CTA_RS_CLEAN_UNQ);
			line_txn = maint || lock_ok || (snoop == `CTA_RS_NSD) || (snoop == `CTA_RS_UNIQUE)
				|| (snoop == `CTA_RS_MAKE_UNQ);
			once_txn = (snoop == `CTA_RS_ONCE) && shareable && !bar;
		end
		if (line_txn) begin
			viol[`CTA_V_DOM_LINE] = !maint && !shareable;
			viol[`CTA_V_DOM_MAINT] = maint && (domain == `CTA_DOM_SYS);
			viol[`CTA_V_BAR] = bar;
			viol[`CTA_V_CACHE] = !cache[`CTA_CACHE_MOD_BIT];
			viol[`CTA_V_LOCK] = lock && !lock_ok;
			viol[`CTA_V_SIZE] = size != `CTA_BUS_LOG;
			viol[`CTA_V_LINE_LEN] = !cta_pow2_len(len) || (bytes != `CTA_LINE_BYTES);
			if (burst == `CTA_BURST_INCR) begin
				viol[`CTA_V_ALIGN] = addr[`CTA_LINE_LOG-1:0] != '0;
			end else if (burst == `CTA_BURST_WRAP) begin
				viol[`CTA_V_ALIGN] = addr[`CTA_BUS_LOG-1:0] != '0;
			end else begin
				viol[`CTA_V_BURST] = 1'b1;
			end
		end
		if (once_txn) begin
			// Length and size left free for legacy masters
			viol[`CTA_V_DOM_ONCE] = !shareable;
			viol[`CTA_V_BURST] = (burst != `CTA_BURST_INCR) && (burst != `CTA_BURST_WRAP);
			viol[`CTA_V_CACHE] = !cache[`CTA_CACHE_MOD_BIT];
			viol[`CTA_V_LOCK] = lock;
		end
		if (wb_txn) begin
			viol[`CTA_V_DOM_SYS] = domain == `CTA_DOM_SYS;
			viol[`CTA_V_BAR] = bar;
			viol[`CTA_V_CACHE] = !cache[`CTA_CACHE_MOD_BIT];
			viol[`CTA_V_LOCK] = lock;
			if (burst == `CTA_BURST_WRAP) begin
				viol[`CTA_V_WB_WRAP] = (addr[`CTA_BUS_LOG-1:0] != '0) || (size != `CTA_BUS_LOG)
					|| !cta_pow2_len(len) || (len == 8'h00) || (bytes > `CTA_LINE_BYTES);
			end else if (burst == `CTA_BURST_INCR) begin
				viol[`CTA_V_WB_INCR] = (len > 8'h0F)
					|| (end_addr[`CTA_ADDR_W-1:`CTA_LINE_LOG] != addr[`CTA_ADDR_W-1:`CTA_LINE_LOG]);
			end else begin
				viol[`CTA_V_BURST] = 1'b1;
			end
		end
		if (report_txn && filter_on) begin
			viol[`CTA_V_DOM_TRUE] = domain != true_dom;
		end
	end
endmodule
`default_nettype wire

// ### verilog/cta_checker.sv
// Checker watching a coherent master's AR, AW and W channels.
// Assumes write data never leads its address and all inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "cta_defines.svh"

module cta_checker
	import cta_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic snoop_filter_present,
	input wire logic [1:0] true_domain,
	input wire logic ar_valid,
	input wire logic ar_ready,
	input wire logic [`CTA_ADDR_W-1:0] ar_addr,
	input wire logic [7:0] ar_len,
	input wire logic [2:0] ar_size,
	input wire logic [1:0] ar_burst,
	input wire logic ar_lock,
	input wire logic [3:0] ar_cache,
	input wire logic [1:0] ar_domain,
	input wire logic [3:0] ar_snoop,
	input wire logic ar_bar,
	input wire logic aw_valid,
	input wire logic aw_ready,
	input wire logic [`CTA_ADDR_W-1:0] aw_addr,
	input wire logic [7:0] aw_len,
	input wire logic [2:0] aw_size,
	input wire logic [1:0] aw_burst,
	input wire logic aw_lock,
	input wire logic [3:0] aw_cache,
	input wire logic [1:0] aw_domain,
	input wire logic [2:0] aw_snoop,
	input wire logic aw_bar,
	input wire logic w_valid,
	input wire logic w_ready,
	input wire logic [`CTA_BUS_BYTES-1:0] w_strb,
	input wire logic w_last,
	input wire logic flags_clear,
	output logic [`CTA_NVIOL-1:0] viol_flags,
	output logic viol_pulse,
	output logic [3:0] first_code,
	output logic first_valid
);
	// ****************************************************************
	// Address channel checks
	// ****************************************************************
	logic ar_fire;
	logic aw_fire;
	logic w_fire;
	logic [`CTA_NVIOL-1:0] rd_viol;
	logic [`CTA_NVIOL-1:0] wr_viol;

	assign ar_fire = ar_valid && ar_ready;
	assign aw_fire = aw_valid && aw_ready;
	assign w_fire = w_valid && w_ready;

	cta_addr_check u_rd_check (
		.is_write(1'b0),
		.addr(ar_addr),
		.len(ar_len),
		.size(ar_size),
		.burst(ar_burst),
		.lock(ar_lock),
		.cache(ar_cache),
		.domain(ar_domain),
		.snoop(ar_snoop),
		.bar(ar_bar),
		.filter_on(snoop_filter_present),
		.true_dom(true_domain),
		.viol(rd_viol)
	);

	cta_addr_check u_wr_check (
		.is_write(1'b1),
		.addr(aw_addr),
		.len(aw_len),
		.size(aw_size),
		.burst(aw_burst),
		.lock(aw_lock),
		.cache(aw_cache),
		.domain(aw_domain),
		.snoop({1'b0, aw_snoop}),
		.bar(aw_bar),
		.filter_on(snoop_filter_present),
		.true_dom(true_domain),
		.viol(wr_viol)
	);

	// ****************************************************************
	// Write strobe tracking
	// ****************************************************************
	// One bit per outstanding write: full strobes demanded
	logic need_full [0:`CTA_WQ_DEPTH-1];
	logic next_need_full [0:`CTA_WQ_DEPTH-1];
	logic [1:0] wq_wr;
	logic [1:0] next_wq_wr;
	logic [1:0] wq_rd;
	logic [1:0] next_wq_rd;
	logic [2:0] wq_count;
	logic [2:0] next_wq_count;
	cta_wstate_type wstate;
	cta_wstate_type next_wstate;
	logic push;
	logic pop;
	logic strb_viol;
	logic ovf_viol;

	always_comb begin
		next_need_full = need_full;
		next_wq_wr = wq_wr;
		next_wq_rd = wq_rd;
		next_wq_count = wq_count;
		next_wstate = wstate;
		push = aw_fire && (wq_count != `CTA_WQ_FULL);
		pop = w_fire && w_last && (wq_count != 3'h0);
		ovf_viol = aw_fire && (wq_count == `CTA_WQ_FULL);
		// Sparse strobes pass for all but WriteLineUnique without a barrier
		strb_viol = w_fire && (wq_count != 3'h0) && need_full[wq_rd] && (w_strb != '1);
		if (push) begin
			next_need_full[wq_wr] = (aw_snoop == `CTA_WS_LINE_UNQ) && !aw_bar;
			next_wq_wr = wq_wr + 2'h1;
		end
		if (pop) begin
			next_wq_rd = wq_rd + 2'h1;
		end
		next_wq_count = 3'(wq_count + {2'h0, push} - {2'h0, pop});
		case (wstate)
			CTA_W_IDLE: begin
				if (w_fire && !w_last) begin
					next_wstate = CTA_W_BURST;
				end
			end
			CTA_W_BURST: begin
				if (w_fire && w_last) begin
					next_wstate = CTA_W_IDLE;
				end
			end
			default: begin
				next_wstate = CTA_W_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `CTA_WQ_DEPTH; i++) begin
				need_full[i] <= 1'b0;
			end
			wq_wr <= 2'h0;
			wq_rd <= 2'h0;
			wq_count <= 3'h0;
			wstate <= CTA_W_IDLE;
		end else if (ce) begin
			need_full <= next_need_full;
			wq_wr <= next_wq_wr;
			wq_rd <= next_wq_rd;
			wq_count <= next_wq_count;
			wstate <= next_wstate;
		end
	end

	// ****************************************************************
	// Sticky violation flags
	// ****************************************************************
	function automatic logic [3:0] cta_first(input logic [`CTA_NVIOL-1:0] v);
		cta_first = 4'h0;
		for (int i = `CTA_NVIOL - 1; i >= 0; i--) begin
			if (v[i]) begin
				cta_first = 4'(i);
			end
		end
	endfunction

	logic [`CTA_NVIOL-1:0] new_viol;
	logic [`CTA_NVIOL-1:0] next_viol_flags;
	logic next_viol_pulse;
	logic [3:0] next_first_code;
	logic next_first_valid;

	always_comb begin
		new_viol = (ar_fire ? rd_viol : '0) | (aw_fire ? wr_viol : '0);
		new_viol[`CTA_V_STRB] = new_viol[`CTA_V_STRB] | strb_viol;
		new_viol[`CTA_V_WQ_OVF] = new_viol[`CTA_V_WQ_OVF] | ovf_viol;
		// Set wins over a clear in the same cycle
		next_viol_flags = (flags_clear ? '0 : viol_flags) | new_viol;
		next_viol_pulse = new_viol != '0;
		next_first_code = first_code;
		next_first_valid = first_valid && !flags_clear;
		if (!next_first_valid && (new_viol != '0)) begin
			next_first_code = cta_first(new_viol);
			next_first_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			viol_flags <= '0;
			viol_pulse <= 1'b0;
			first_code <= 4'h0;
			first_valid <= 1'b0;
		end else if (ce) begin
			viol_flags <= next_viol_flags;
			viol_pulse <= next_viol_pulse;
			first_code <= next_first_code;
			first_valid <= next_first_valid;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cta_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [`CTA_ADDR_W-1:0] aw_end;
	assign aw_end = aw_addr + {16'h0000, 16'(({8'h00, aw_len} + 16'h0001) << aw_size)} - 32'h1;

	line_cfg_a: assert property ((`CTA_LINE_BYTES >= `CTA_LINE_MIN) && (`CTA_LINE_BYTES >= `CTA_BUS_BYTES)
		&& (`CTA_LINE_BYTES <= `CTA_LINE_MAX) && (`CTA_LINE_BYTES <= `CTA_MAX_BEATS * `CTA_BUS_BYTES))
		else $error("line size outside legal range");
	dom_line_a: assert property (ce && ar_fire && (ar_snoop == `CTA_RS_UNIQUE) && (ar_domain == `CTA_DOM_NS)
		|=> viol_flags[`CTA_V_DOM_LINE])
		else $error("non-shareable line read not flagged");
	maint_dom_a: assert property (ar_fire && (ar_snoop == `CTA_RS_CLEAN_SH)
		|-> !rd_viol[`CTA_V_DOM_LINE] && (rd_viol[`CTA_V_DOM_MAINT] == (ar_domain == `CTA_DOM_SYS)))
		else $error("maintenance domain check wrong");
	maint_ns_a: assert property (ar_fire && (ar_snoop == `CTA_RS_CLEAN_INV) && (ar_domain == `CTA_DOM_NS)
		|-> !rd_viol[`CTA_V_DOM_LINE] && !rd_viol[`CTA_V_DOM_MAINT])
		else $error("non-shareable maintenance wrongly refused");
	bar_line_a: assert property (ce && aw_fire && (aw_snoop == `CTA_WS_LINE_UNQ) && aw_bar
		|=> viol_flags[`CTA_V_BAR])
		else $error("barrier line write not flagged");
	lock_line_a: assert property (ce && ar_fire && ar_lock && (ar_snoop == `CTA_RS_UNIQUE)
		|=> viol_flags[`CTA_V_LOCK])
		else $error("locked line read not flagged");
	strb_full_a: assert property (ce && w_fire && (wq_count != 3'h0) && need_full[wq_rd] && (w_strb != '1)
		|=> viol_flags[`CTA_V_STRB] && viol_pulse)
		else $error("partial strobe not flagged");
	sparse_ok_a: assert property (w_fire && ((wq_count == 3'h0) || !need_full[wq_rd]) |-> !strb_viol)
		else $error("sparse strobe wrongly refused");
	evict_len_a: assert property (ce && aw_fire && !aw_bar && (aw_snoop == `CTA_WS_EVICT)
		&& (aw_size == `CTA_BUS_LOG) && (aw_len == 8'h00) |=> viol_flags[`CTA_V_LINE_LEN])
		else $error("short evict not flagged");
	once_free_a: assert property (ar_fire && (ar_snoop == `CTA_RS_ONCE) && !ar_bar
		|-> !rd_viol[`CTA_V_LINE_LEN] && !rd_viol[`CTA_V_SIZE])
		else $error("read once held to line size");
	once_fixed_a: assert property (ce && ar_fire && !ar_bar && (ar_snoop == `CTA_RS_ONCE)
		&& ((ar_domain == `CTA_DOM_IS) || (ar_domain == `CTA_DOM_OS)) && (ar_burst == `CTA_BURST_FIXED)
		|=> viol_flags[`CTA_V_BURST])
		else $error("fixed read once not flagged");
	wb_wrap_a: assert property (ce && aw_fire && ((aw_snoop == `CTA_WS_BACK) || (aw_snoop == `CTA_WS_CLEAN))
		&& (aw_burst == `CTA_BURST_WRAP) && (aw_len == 8'h02) |=> viol_flags[`CTA_V_WB_WRAP])
		else $error("three beat wrap writeback not flagged");
	wb_cross_a: assert property (ce && aw_fire && ((aw_snoop == `CTA_WS_CLEAN) || (aw_snoop == `CTA_WS_BACK))
		&& (aw_burst == `CTA_BURST_INCR) && (aw_size == `CTA_BUS_LOG) && (aw_addr[`CTA_BUS_LOG-1:0] == '0)
		&& (aw_end[`CTA_ADDR_W-1:`CTA_LINE_LOG] != aw_addr[`CTA_ADDR_W-1:`CTA_LINE_LOG])
		|=> viol_flags[`CTA_V_WB_INCR])
		else $error("line crossing writeback not flagged");
	incr_len_a: assert property (ce && aw_fire && (aw_snoop == `CTA_WS_BACK) && (aw_burst == `CTA_BURST_INCR)
		&& (aw_len > 8'h0F) |=> viol_flags[`CTA_V_WB_INCR])
		else $error("long incrementing writeback not flagged");
	wb_sys_a: assert property (ce && aw_fire && (aw_snoop == `CTA_WS_BACK) && (aw_domain == `CTA_DOM_SYS)
		|=> viol_flags[`CTA_V_DOM_SYS])
		else $error("system writeback not flagged");
	true_dom_a: assert property (aw_fire && (aw_snoop == `CTA_WS_EVICT)
		|-> wr_viol[`CTA_V_DOM_TRUE] == (snoop_filter_present && (aw_domain != true_domain)))
		else $error("evict domain report check wrong");
	evict_dom_a: assert property (ce && aw_fire && snoop_filter_present && (aw_snoop == `CTA_WS_EVICT)
		&& (aw_domain != true_domain) |=> viol_flags[`CTA_V_DOM_TRUE])
		else $error("evict domain mismatch not flagged");
	nofilter_dom_a: assert property (aw_fire && !snoop_filter_present && (aw_snoop == `CTA_WS_BACK)
		&& (aw_domain != `CTA_DOM_SYS) |-> !wr_viol[`CTA_V_DOM_TRUE] && !wr_viol[`CTA_V_DOM_SYS])
		else $error("writeback domain wrongly refused");
	pulse_once_a: assert property (ce && (new_viol == '0) |=> !viol_pulse)
		else $error("pulse without new violation");
	ovf_flag_a: assert property (ce && aw_fire && (wq_count == `CTA_WQ_FULL) |=> viol_flags[`CTA_V_WQ_OVF])
		else $error("tracking overflow not flagged");
	ce_freeze_a: assert property (!ce |=> $stable(viol_flags) && $stable(wq_count))
		else $error("state moved while disabled");
	sticky_hold_a: assert property (!flags_clear |=> ((viol_flags & $past(viol_flags)) == $past(viol_flags)))
		else $error("violation flag lost without clear");
	first_lock_a: assert property (first_valid && !flags_clear |=> first_valid && $stable(first_code))
		else $error("first code changed while held");

	wlu_cov: cover property (ce && w_fire && w_last && (wq_count != 3'h0) && need_full[wq_rd]);
	burst_cov: cover property (wstate == CTA_W_BURST ##1 wstate == CTA_W_IDLE);
	clear_set_cov: cover property (ce && flags_clear && (new_viol != '0));
	ovf_cov: cover property (ce && ovf_viol);
	filter_cov: cover property (ce && aw_fire && snoop_filter_present && wr_viol[`CTA_V_DOM_TRUE]);
endmodule
`default_nettype wire

// ### bench/cta_ic_model.sv
// Interconnect stand-in: channel readies and snoop filter state.
// Assumes it shares clk and rst with the checker.
`timescale 1ns/1ps
`default_nettype none
`include "cta_defines.svh"

module cta_ic_model
	import cta_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic filter_on,
	input wire logic [1:0] line_dom,
	output logic ar_ready,
	output logic aw_ready,
	output logic w_ready,
	output logic snoop_filter_present,
	output logic [1:0] true_domain
);
	logic rdy;
	logic next_rdy;

	// Slow mode accepts every other cycle
	always_comb begin
		next_rdy = slow ? !rdy : 1'h1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdy <= 1'h0;
		end else begin
			rdy <= next_rdy;
		end
	end

	assign ar_ready = rdy;
	assign aw_ready = rdy;
	assign w_ready = rdy;
	assign snoop_filter_present = filter_on;
	// Non-shareable lines are never tracked
	assign true_domain = (filter_on && line_dom != `CTA_DOM_NS) ? line_dom : `CTA_DOM_NS;
endmodule
`default_nettype wire

// ### bench/cta_checker_test.sv
// Self-checking bench for the coherent transaction attribute checker.
// Assumes cta_pkg, cta_checker and cta_ic_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cta_defines.svh"

module cta_checker_test
	import cta_pkg::*;
;
	logic clk, rst, ce, slow, filt, flags_clear, snoop_filter_present;
	logic [1:0] ldom, true_domain;
	logic ar_valid, ar_ready, ar_lock, ar_bar, aw_valid, aw_ready, aw_lock, aw_bar;
	logic w_valid, w_ready, w_last, viol_pulse, first_valid;
	logic [`CTA_ADDR_W-1:0] ar_addr, aw_addr;
	logic [7:0] ar_len, aw_len;
	logic [2:0] ar_size, aw_size, aw_snoop;
	logic [1:0] ar_burst, aw_burst, ar_domain, aw_domain;
	logic [3:0] ar_cache, aw_cache, ar_snoop, first_code;
	logic [15:0] w_strb, viol_flags;
	int err_count, n_compared, cycles;

	cta_checker DUT(.clk(clk), .rst(rst), .ce(ce), .snoop_filter_present(snoop_filter_present),
		.true_domain(true_domain), .ar_valid(ar_valid), .ar_ready(ar_ready), .ar_addr(ar_addr),
		.ar_len(ar_len), .ar_size(ar_size), .ar_burst(ar_burst), .ar_lock(ar_lock), .ar_cache(ar_cache),
		.ar_domain(ar_domain), .ar_snoop(ar_snoop), .ar_bar(ar_bar), .aw_valid(aw_valid),
		.aw_ready(aw_ready), .aw_addr(aw_addr), .aw_len(aw_len), .aw_size(aw_size), .aw_burst(aw_burst),
		.aw_lock(aw_lock), .aw_cache(aw_cache), .aw_domain(aw_domain), .aw_snoop(aw_snoop), .aw_bar(aw_bar),
		.w_valid(w_valid), .w_ready(w_ready), .w_strb(w_strb), .w_last(w_last), .flags_clear(flags_clear),
		.viol_flags(viol_flags), .viol_pulse(viol_pulse), .first_code(first_code), .first_valid(first_valid));

	cta_ic_model u_ic(.clk(clk), .rst(rst), .slow(slow), .filter_on(filt), .line_dom(ldom),
		.ar_ready(ar_ready), .aw_ready(aw_ready), .w_ready(w_ready),
		.snoop_filter_present(snoop_filter_present), .true_domain(true_domain));

	// ****
	// Clock, timeout and report
	// ****
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// Whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ****
	// Channel drivers
	// ****
	task automatic do_reset();
		@(posedge clk);
		#1 rst = 1'h1;
		repeat (2) @(posedge clk);
		#1 rst = 1'h0;
	endtask

	task automatic ax(input bit wr, input logic [3:0] snp, input logic [1:0] dom, input logic bar,
		input logic lock, input logic [3:0] cache, input logic [1:0] burst, input logic [2:0] size,
		input logic [7:0] len, input logic [31:0] addr);
		int n;
		@(posedge clk);
		#1;
		if (wr) begin
			{aw_snoop, aw_domain, aw_bar, aw_lock, aw_cache} = {snp[2:0], dom, bar, lock, cache};
			{aw_burst, aw_size, aw_len, aw_addr, aw_valid} = {burst, size, len, addr, 1'h1};
		end else begin
			{ar_snoop, ar_domain, ar_bar, ar_lock, ar_cache} = {snp, dom, bar, lock, cache};
			{ar_burst, ar_size, ar_len, ar_addr, ar_valid} = {burst, size, len, addr, 1'h1};
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((wr ? aw_ready : ar_ready) !== 1'h1 && n < 50);
		#1 {ar_valid, aw_valid} = 2'h0;
		ar_addr = ~ar_addr;
		aw_addr = ~aw_addr;
	endtask

	task automatic wbeat(input logic [15:0] strb, input logic last);
		int n;
		@(posedge clk);
		#1 {w_valid, w_strb, w_last} = {1'h1, strb, last};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (w_ready !== 1'h1 && n < 50);
		#1 w_valid = 1'h0;
		w_strb = ~strb;
	endtask

	// Flags and pulse stand from the taking edge on
	task automatic expect_v(input logic [15:0] m);
		chk(viol_flags, m);
		chk({15'h0, viol_pulse}, {15'h0, |m});
		do_reset();
	endtask

	task automatic ln(input bit wr, input logic [3:0] snp, input logic [1:0] dom, input logic bar,
		input logic lock);
		ax(wr, snp, dom, bar, lock, 4'h2, 2'h1, 3'h4, 8'h03, 32'h0);
	endtask

	task automatic tx(input bit wr, input logic [3:0] snp, input logic [1:0] dom, input logic [1:0] burst,
		input logic [2:0] size, input logic [7:0] len, input logic [31:0] addr, input logic [15:0] m);
		ax(wr, snp, dom, 1'h0, 1'h0, 4'h2, burst, size, len, addr);
		expect_v(m);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic s_dom();
		slow = 1'h1;
		tx(1'h0, 4'h1, 2'h0, 2'h1, 3'h4, 8'h03, 32'h0, 16'h0001);
		tx(1'h0, 4'h8, 2'h3, 2'h1, 3'h4, 8'h03, 32'h0, 16'h0002);
		tx(1'h0, 4'h9, 2'h0, 2'h1, 3'h4, 8'h03, 32'h0, 16'h0000);
		ln(1'h0, 4'h7, 2'h2, 1'h1, 1'h0);
		expect_v(16'h0004);
		ln(1'h1, 4'h1, 2'h2, 1'h1, 1'h0);
		expect_v(16'h0004);
		slow = 1'h0;
	endtask

	task automatic s_lock();
		logic [3:0] snp [9] = '{4'h2, 4'h1, 4'hB, 4'h3, 4'h7, 4'hC, 4'h8, 4'h9, 4'hD};
		for (int i = 0; i < 9; i++) begin
			ln(1'h0, snp[i], 2'h1, 1'h0, 1'h1);
			expect_v(i < 3 ? 16'h0000 : 16'h0008);
		end
		ln(1'h1, 4'h1, 2'h1, 1'h0, 1'h1);
		expect_v(16'h0008);
		ln(1'h1, 4'h4, 2'h1, 1'h0, 1'h1);
		expect_v(16'h0008);
	endtask

	task automatic s_wlu();
		ln(1'h1, 4'h1, 2'h2, 1'h0, 1'h0);
		wbeat(16'hFFFF, 1'h0);
		wbeat(16'hFFFE, 1'h0);
		expect_v(16'h0010);
	endtask

	task automatic s_len();
		tx(1'h0, 4'hB, 2'h1, 2'h1, 3'h4, 8'h00, 32'h0, 16'h0020);
		tx(1'h1, 4'h4, 2'h1, 2'h1, 3'h4, 8'h00, 32'h0, 16'h0020);
		tx(1'h0, 4'h1, 2'h1, 2'h1, 3'h3, 8'h07, 32'h0, 16'h0040);
		tx(1'h0, 4'h1, 2'h1, 2'h1, 3'h4, 8'h03, 32'h50, 16'h0080);
		tx(1'h0, 4'h1, 2'h1, 2'h2, 3'h4, 8'h03, 32'h50, 16'h0000);
	endtask

	task automatic s_once();
		tx(1'h0, 4'h0, 2'h1, 2'h1, 3'h0, 8'h00, 32'h3, 16'h0000);
		tx(1'h0, 4'h0, 2'h2, 2'h0, 3'h2, 8'h01, 32'h0, 16'h0100);
		tx(1'h1, 4'h0, 2'h1, 2'h0, 3'h2, 8'h01, 32'h0, 16'h0100);
		ax(1'h0, 4'h0, 2'h1, 1'h0, 1'h0, 4'h0, 2'h1, 3'h2, 8'h01, 32'h0);
		expect_v(16'h0200);
		ax(1'h0, 4'h0, 2'h2, 1'h0, 1'h1, 4'h2, 2'h2, 3'h2, 8'h01, 32'h0);
		expect_v(16'h0008);
		ax(1'h1, 4'h0, 2'h1, 1'h0, 1'h0, 4'h2, 2'h1, 3'h4, 8'h00, 32'h4);
		wbeat(16'h0001, 1'h1);
		expect_v(16'h0000);
	endtask

	task automatic s_wb();
		for (int i = 2; i < 4; i++) begin
			tx(1'h1, i[3:0], 2'h3, 2'h1, 3'h4, 8'h00, 32'h0, 16'h0800);
		end
		tx(1'h1, 4'h3, 2'h0, 2'h2, 3'h4, 8'h03, 32'h20, 16'h0000);
		tx(1'h1, 4'h2, 2'h0, 2'h2, 3'h4, 8'h02, 32'h0, 16'h2000);
		tx(1'h1, 4'h3, 2'h0, 2'h2, 3'h4, 8'h07, 32'h0, 16'h2000);
		tx(1'h1, 4'h3, 2'h0, 2'h2, 3'h4, 8'h01, 32'h28, 16'h2000);
		tx(1'h1, 4'h3, 2'h0, 2'h2, 3'h3, 8'h01, 32'h0, 16'h2000);
		tx(1'h1, 4'h3, 2'h0, 2'h1, 3'h4, 8'h01, 32'h30, 16'h4000);
		tx(1'h1, 4'h2, 2'h0, 2'h1, 3'h0, 8'h0F, 32'h30, 16'h0000);
		tx(1'h1, 4'h3, 2'h0, 2'h1, 3'h0, 8'h10, 32'h0, 16'h4000);
		ax(1'h1, 4'h3, 2'h1, 1'h0, 1'h0, 4'h2, 2'h1, 3'h4, 8'h00, 32'h0);
		wbeat(16'h0F00, 1'h1);
		expect_v(16'h0000);
	endtask

	task automatic s_filter();
		{filt, ldom} = {1'h1, 2'h1};
		tx(1'h1, 4'h3, 2'h0, 2'h1, 3'h4, 8'h00, 32'h0, 16'h1000);
		tx(1'h1, 4'h2, 2'h1, 2'h1, 3'h4, 8'h00, 32'h0, 16'h0000);
		tx(1'h1, 4'h4, 2'h2, 2'h1, 3'h4, 8'h03, 32'h0, 16'h1000);
		filt = 1'h0;
	endtask

	task automatic s_first();
		ln(1'h0, 4'h7, 2'h0, 1'h0, 1'h1);
		chk(viol_flags, 16'h0009);
		ln(1'h0, 4'h7, 2'h1, 1'h1, 1'h0);
		chk(viol_flags, 16'h000D);
		chk({11'h0, viol_pulse, first_valid, first_code}, 16'h0030);
		flags_clear = 1'h1;
		@(posedge clk);
		#1 flags_clear = 1'h0;
		chk({viol_flags[14:0], viol_pulse}, 16'h0000);
		chk({15'h0, first_valid}, 16'h0000);
		do_reset();
	endtask

	task automatic s_misc();
		repeat (4) ax(1'h1, 4'h3, 2'h0, 1'h0, 1'h0, 4'h2, 2'h1, 3'h4, 8'h00, 32'h0);
		tx(1'h1, 4'h3, 2'h0, 2'h1, 3'h4, 8'h00, 32'h0, 16'h8000);
		ce = 1'h0;
		ln(1'h0, 4'h1, 2'h0, 1'h0, 1'h0);
		ce = 1'h1;
		expect_v(16'h0000);
	endtask

	initial begin
		{ar_valid, ar_addr, ar_len, ar_size, ar_burst, ar_lock, ar_cache, ar_domain, ar_snoop, ar_bar} = '0;
		{aw_valid, aw_addr, aw_len, aw_size, aw_burst, aw_lock, aw_cache, aw_domain, aw_snoop, aw_bar} = '0;
		{w_valid, w_strb, w_last, slow, filt, flags_clear, ldom} = '0;
		ce = 1'h1;
		rst = 1'h1;
		repeat (2) @(posedge clk);
		#1 rst = 1'h0;
		s_dom();
		s_lock();
		s_wlu();
		s_len();
		s_once();
		s_wb();
		s_filter();
		s_first();
		s_misc();
		finish_test();
	end
endmodule
`default_nettype wire
